//--- rtl/dif_pkg.sv
// constants, register map and types for the digital IF receive chain
package dif_pkg;
	// datapath widths
	localparam int ADC_W = 14;
	localparam int SMP_W = 18;
	localparam int ACC_W = 20;
	localparam int OUT_W = 16;
	localparam int CW = 18;
	localparam int PH_W = 16;
	localparam int NST = 4;
	localparam int NCORD = 12;
	localparam int GAIN_W = 2;
	localparam logic [GAIN_W-1:0] GAIN_MAX = 2'h3;
	// analog path lead of the anti-alias filter, in samples
	localparam int AA_LEAD = 3;
	// quiet time before the autorange raises gain
	localparam int CLK_NS = 8;
	localparam int HOLD_NS = 10000;
	localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [10:0] HOLD_LAST = 11'(HOLD_CYC - 1);
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_RBW = 8'h04;
	localparam logic [7:0] OFS_VBW = 8'h08;
	localparam logic [7:0] OFS_DECIM = 8'h0C;
	localparam logic [7:0] OFS_BUCKET = 8'h10;
	localparam logic [7:0] OFS_THR = 8'h14;
	localparam logic [7:0] OFS_STEPLEN = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1C;
	localparam logic [7:0] OFS_COMP = 8'h20;
	// control fields
	localparam int CTRL_AR_EN = 0;
	localparam int CTRL_STEP = 1;
	localparam int CTRL_PEAK = 2;
	localparam int CTRL_MGAIN = 4;
	localparam int THR_LO = 0;
	localparam int THR_HI = 16;
	// resolution_bandwidth index range and mapping
	localparam logic [7:0] RBW_MAX = 8'h9F;
	localparam logic [7:0] NARROW_MAX = 8'h05;
	localparam logic [3:0] SHIFT_BASE = 4'hA;
	// reset values
	localparam logic [7:0] CTRL_RST = 8'h31;
	localparam logic [7:0] RBW_RST = 8'h50;
	localparam logic [3:0] VBW_RST = 4'h2;
	localparam logic [3:0] COMP_RST = 4'h2;
	localparam logic [15:0] DECIM_RST = 16'h0000;
	localparam logic [15:0] BUCKET_RST = 16'h00FF;
	localparam logic [31:0] THR_RST = 32'h1800_0400;
	localparam logic [15:0] STEPLEN_RST = 16'h03FF;
	// arctangent of 2^-k, full turn = 2^16, entry k at bits [16k +: 16]
	localparam logic [NCORD*PH_W-1:0] ATAN_LUT = {16'h0005, 16'h000A, 16'h0014, 16'h0029, 16'h0051, 16'h00A3,
		16'h0146, 16'h028B, 16'h0511, 16'h09FB, 16'h12E4, 16'h2000};
	localparam logic [PH_W-1:0] PHASE_PI = 16'h8000;
	typedef enum logic [1:0] {ST_IDLE, ST_CAPT, ST_STEP} step_state_t;
endpackage : dif_pkg

//--- rtl/digital_if_receive_chain.sv
// digital IF receive chain: autorange, I/Q split, filtering, decimation, magnitude/phase, video, detector
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ns
module digital_if_receive_chain (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [dif_pkg::ADC_W-1:0] adc_data,
	input wire logic [15:0] env_early,
	output logic [dif_pkg::GAIN_W-1:0] analog_gain,
	output logic [dif_pkg::OUT_W-1:0] iq_i,
	output logic [dif_pkg::OUT_W-1:0] iq_q,
	output logic iq_valid,
	output logic [dif_pkg::OUT_W-1:0] mag,
	output logic [dif_pkg::PH_W-1:0] phase,
	output logic mp_valid,
	output logic [dif_pkg::OUT_W-1:0] trace_pt,
	output logic trace_valid,
	output logic tune_hold,
	output logic tune_step,
	output logic analog_rbw_sel
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	logic [7:0] ctrl_ff, rbw_ff;
	logic [3:0] vbw_ff, comp_ff;
	logic [15:0] decim_ff, bucket_ff, steplen_ff;
	logic [31:0] thr_ff, rd_val, prdata_ff;
	logic hit, pready_ff, pslverr_ff;
	logic setup, access, stepped, ar_on;
	dif_pkg::step_state_t st_ff;

	assign setup = psel & ~penable;
	assign access = psel & penable & pready_ff;
	assign stepped = ctrl_ff[dif_pkg::CTRL_STEP];
	assign ar_on = ctrl_ff[dif_pkg::CTRL_AR_EN] & ~stepped;

	logic [dif_pkg::GAIN_W-1:0] gain_ff;
	logic [10:0] quiet_ff;
	logic analog_rbw_ff;

	// read mux; unmapped offsets answer with pslverr and zero data
	always_comb begin
		hit = 1'b1;
		rd_val = '0;
		case (paddr)
			dif_pkg::OFS_CTRL: rd_val = {24'h000000, ctrl_ff};
			dif_pkg::OFS_RBW: rd_val = {24'h000000, rbw_ff};
			dif_pkg::OFS_VBW: rd_val = {28'h0000000, vbw_ff};
			dif_pkg::OFS_DECIM: rd_val = {16'h0000, decim_ff};
			dif_pkg::OFS_BUCKET: rd_val = {16'h0000, bucket_ff};
			dif_pkg::OFS_THR: rd_val = thr_ff;
			dif_pkg::OFS_STEPLEN: rd_val = {16'h0000, steplen_ff};
			dif_pkg::OFS_STATUS: rd_val = {27'h0000000, analog_rbw_ff, st_ff, gain_ff};
			dif_pkg::OFS_COMP: rd_val = {28'h0000000, comp_ff};
			default: hit = 1'b0;
		endcase
	end

	// apb answer: read data latched in setup, one access cycle, no wait states
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= '0;
		end else begin
			pready_ff <= setup;
			pslverr_ff <= setup & ~hit;
			prdata_ff <= (setup & ~pwrite) ? rd_val : '0;
		end
	end

	// register writes take effect at the sampled access edge
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_ff <= dif_pkg::CTRL_RST;
			rbw_ff <= dif_pkg::RBW_RST;
			vbw_ff <= dif_pkg::VBW_RST;
			comp_ff <= dif_pkg::COMP_RST;
			decim_ff <= dif_pkg::DECIM_RST;
			bucket_ff <= dif_pkg::BUCKET_RST;
			thr_ff <= dif_pkg::THR_RST;
			steplen_ff <= dif_pkg::STEPLEN_RST;
		end else if (access & pwrite & hit) begin
			case (paddr)
				dif_pkg::OFS_CTRL: ctrl_ff <= pwdata[7:0];
				// out-of-range indices clamp to the widest setting
				dif_pkg::OFS_RBW: rbw_ff <= (pwdata[7:0] > dif_pkg::RBW_MAX) ? dif_pkg::RBW_MAX : pwdata[7:0];
				dif_pkg::OFS_VBW: vbw_ff <= pwdata[3:0];
				dif_pkg::OFS_DECIM: decim_ff <= pwdata[15:0];
				dif_pkg::OFS_BUCKET: bucket_ff <= pwdata[15:0];
				dif_pkg::OFS_THR: thr_ff <= pwdata;
				dif_pkg::OFS_STEPLEN: steplen_ff <= pwdata[15:0];
				dif_pkg::OFS_COMP: comp_ff <= pwdata[3:0];
				default: ;
			endcase
		end
	end

	// autorange: the early envelope leads the adc by the anti-alias delay, so gain drops in time
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			gain_ff <= '0;
			quiet_ff <= '0;
		end else if (!ar_on) begin
			gain_ff <= ctrl_ff[dif_pkg::CTRL_MGAIN +: dif_pkg::GAIN_W];
			quiet_ff <= '0;
		end else if (env_early > thr_ff[dif_pkg::THR_HI +: 16]) begin
			if (gain_ff != '0)
				gain_ff <= gain_ff - 2'h1;
			quiet_ff <= '0;
		end else if (env_early < thr_ff[dif_pkg::THR_LO +: 16]) begin
			if (quiet_ff == dif_pkg::HOLD_LAST) begin
				quiet_ff <= '0;
				if (gain_ff != dif_pkg::GAIN_MAX)
					gain_ff <= gain_ff + 2'h1;
			end else
				quiet_ff <= quiet_ff + 11'h001;
		end else
			quiet_ff <= '0;
	end

	// gain code delayed by the analog lead so correction lands on the affected sample
	logic [dif_pkg::GAIN_W-1:0] gdly [0:dif_pkg::AA_LEAD-1];
	genvar d;
	generate
		for (d = 0; d < dif_pkg::AA_LEAD; d++) begin : g_dly
			always_ff @(posedge core_clk or negedge rst_n) begin
				if (!rst_n)
					gdly[d] <= '0;
				else
					gdly[d] <= (d == 0) ? gain_ff : gdly[(d == 0) ? 0 : d-1];
			end
		end
	endgenerate

	// digital gain is the inverse of analog gain: floating-point style scaling
	logic signed [dif_pkg::SMP_W-1:0] smp_ff, i_raw, q_raw, i_prev, q_prev;
	logic [1:0] ph_ff;
	logic pair_v;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			smp_ff <= '0;
		else
			smp_ff <= dif_pkg::SMP_W'(signed'(adc_data)) <<< (dif_pkg::GAIN_MAX - gdly[dif_pkg::AA_LEAD-1]);
	end

	// fs/4 mix: alternate samples feed I and Q with sign rotation, one pair per two samples
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_ff <= '0;
			pair_v <= 1'b0;
			i_raw <= '0;
			q_raw <= '0;
		end else begin
			ph_ff <= ph_ff + 2'h1;
			pair_v <= ph_ff[0];
			case (ph_ff)
				2'h0: i_raw <= smp_ff;
				2'h1: q_raw <= -smp_ff;
				2'h2: i_raw <= -smp_ff;
				default: q_raw <= smp_ff;
			endcase
		end
	end

	// prefilter inverse: first difference adds the high-frequency lift the pole removed
	logic signed [dif_pkg::ACC_W-1:0] ic_ff, qc_ff;
	logic comp_v;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			i_prev <= '0;
			q_prev <= '0;
			ic_ff <= '0;
			qc_ff <= '0;
			comp_v <= 1'b0;
		end else begin
			comp_v <= pair_v;
			if (pair_v) begin
				i_prev <= i_raw;
				q_prev <= q_raw;
				ic_ff <= dif_pkg::ACC_W'(i_raw) + ((dif_pkg::ACC_W'(i_raw) - dif_pkg::ACC_W'(i_prev)) >>> comp_ff);
				qc_ff <= dif_pkg::ACC_W'(q_raw) + ((dif_pkg::ACC_W'(q_raw) - dif_pkg::ACC_W'(q_prev)) >>> comp_ff);
			end
		end
	end

	// cascaded equal poles approach a Gaussian shape; index picks the smoothing shift
	logic [3:0] rbw_sh;
	logic signed [dif_pkg::ACC_W-1:0] gi [0:dif_pkg::NST];
	logic signed [dif_pkg::ACC_W-1:0] gq [0:dif_pkg::NST];
	assign rbw_sh = dif_pkg::SHIFT_BASE - rbw_ff[7:4];
	assign gi[0] = ic_ff;
	assign gq[0] = qc_ff;
	genvar s;
	generate
		for (s = 0; s < dif_pkg::NST; s++) begin : g_gauss
			always_ff @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					gi[s+1] <= '0;
					gq[s+1] <= '0;
				end else if (comp_v) begin
					gi[s+1] <= gi[s+1] + ((gi[s] - gi[s+1]) >>> rbw_sh);
					gq[s+1] <= gq[s+1] + ((gq[s] - gq[s+1]) >>> rbw_sh);
				end
			end
		end
	endgenerate

	// decimation by span: one pair out of every decim+1
	logic g_v, iq_v_ff;
	logic [15:0] dec_cnt;
	logic [dif_pkg::OUT_W-1:0] iq_i_ff, iq_q_ff;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			g_v <= 1'b0;
			dec_cnt <= '0;
			iq_v_ff <= 1'b0;
			iq_i_ff <= '0;
			iq_q_ff <= '0;
		end else begin
			g_v <= comp_v;
			iq_v_ff <= g_v && dec_cnt == '0;
			if (g_v) begin
				dec_cnt <= (dec_cnt >= decim_ff) ? '0 : dec_cnt + 16'h0001;
				if (dec_cnt == '0) begin
					iq_i_ff <= gi[dif_pkg::NST][dif_pkg::ACC_W-1 -: dif_pkg::OUT_W];
					iq_q_ff <= gq[dif_pkg::NST][dif_pkg::ACC_W-1 -: dif_pkg::OUT_W];
				end
			end
		end
	end

	// cordic vectoring; magnitude carries the fixed cordic gain, the host scale absorbs it
	logic signed [dif_pkg::CW-1:0] cx [0:dif_pkg::NCORD];
	logic signed [dif_pkg::CW-1:0] cy [0:dif_pkg::NCORD];
	logic [dif_pkg::PH_W-1:0] cz [0:dif_pkg::NCORD];
	logic cv [0:dif_pkg::NCORD];
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cx[0] <= '0;
			cy[0] <= '0;
			cz[0] <= '0;
			cv[0] <= 1'b0;
		end else begin
			cv[0] <= iq_v_ff & ~stepped;
			// pre-rotate the left half-plane by pi so the iterations converge
			cx[0] <= iq_i_ff[dif_pkg::OUT_W-1] ? -dif_pkg::CW'(signed'(iq_i_ff)) : dif_pkg::CW'(signed'(iq_i_ff));
			cy[0] <= iq_i_ff[dif_pkg::OUT_W-1] ? -dif_pkg::CW'(signed'(iq_q_ff)) : dif_pkg::CW'(signed'(iq_q_ff));
			cz[0] <= iq_i_ff[dif_pkg::OUT_W-1] ? dif_pkg::PHASE_PI : '0;
		end
	end
	genvar k;
	generate
		for (k = 0; k < dif_pkg::NCORD; k++) begin : g_cordic
			always_ff @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					cx[k+1] <= '0;
					cy[k+1] <= '0;
					cz[k+1] <= '0;
					cv[k+1] <= 1'b0;
				end else begin
					cv[k+1] <= cv[k];
					if (cy[k][dif_pkg::CW-1]) begin
						cx[k+1] <= cx[k] - (cy[k] >>> k);
						cy[k+1] <= cy[k] + (cx[k] >>> k);
						cz[k+1] <= cz[k] - dif_pkg::ATAN_LUT[k*dif_pkg::PH_W +: dif_pkg::PH_W];
					end else begin
						cx[k+1] <= cx[k] + (cy[k] >>> k);
						cy[k+1] <= cy[k] - (cx[k] >>> k);
						cz[k+1] <= cz[k] + dif_pkg::ATAN_LUT[k*dif_pkg::PH_W +: dif_pkg::PH_W];
					end
				end
			end
		end
	endgenerate

	// magnitude/phase out, then video smoothing of the magnitude
	logic [dif_pkg::OUT_W-1:0] mag_ff;
	logic [dif_pkg::PH_W-1:0] phase_ff;
	logic mp_v_ff, vv_ff;
	logic signed [dif_pkg::CW-1:0] vid_ff;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mag_ff <= '0;
			phase_ff <= '0;
			mp_v_ff <= 1'b0;
			vid_ff <= '0;
			vv_ff <= 1'b0;
		end else begin
			mp_v_ff <= cv[dif_pkg::NCORD];
			vv_ff <= mp_v_ff;
			if (cv[dif_pkg::NCORD]) begin
				mag_ff <= cx[dif_pkg::NCORD][dif_pkg::CW-2 -: dif_pkg::OUT_W];
				phase_ff <= cz[dif_pkg::NCORD];
			end
			if (mp_v_ff)
				// signed difference so a falling magnitude pulls the video value down
				vid_ff <= vid_ff + ((signed'(dif_pkg::CW'(mag_ff)) - vid_ff) >>> vbw_ff);
		end
	end

	// display detector: peak or sample over each bucket of bucket+1 video samples
	logic [15:0] bkt_cnt;
	logic signed [dif_pkg::CW-1:0] pk_ff, pk_new;
	logic [dif_pkg::OUT_W-1:0] trace_ff;
	logic trace_v_ff;
	assign pk_new = (bkt_cnt == '0 || vid_ff > pk_ff) ? vid_ff : pk_ff;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			bkt_cnt <= '0;
			pk_ff <= '0;
			trace_ff <= '0;
			trace_v_ff <= 1'b0;
		end else begin
			trace_v_ff <= vv_ff && bkt_cnt >= bucket_ff;
			if (vv_ff) begin
				pk_ff <= pk_new;
				if (bkt_cnt >= bucket_ff) begin
					bkt_cnt <= '0;
					trace_ff <= ctrl_ff[dif_pkg::CTRL_PEAK] ? pk_new[dif_pkg::OUT_W-1:0] : vid_ff[dif_pkg::OUT_W-1:0];
				end else
					bkt_cnt <= bkt_cnt + 16'h0001;
			end
		end
	end

	// stepped mode: hold tuning for one transform block, then step; magnitude, video and display stay idle
	logic [15:0] step_cnt;
	logic hold_ff, step_ff;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= dif_pkg::ST_IDLE;
			step_cnt <= '0;
			hold_ff <= 1'b0;
			step_ff <= 1'b0;
		end else begin
			step_ff <= 1'b0;
			case (st_ff)
				dif_pkg::ST_IDLE: begin
					step_cnt <= '0;
					if (stepped) begin
						st_ff <= dif_pkg::ST_CAPT;
						hold_ff <= 1'b1;
					end
				end
				dif_pkg::ST_CAPT: begin
					if (iq_v_ff) begin
						step_cnt <= step_cnt + 16'h0001;
						if (step_cnt >= steplen_ff) begin
							st_ff <= dif_pkg::ST_STEP;
							hold_ff <= 1'b0;
							step_ff <= 1'b1;
						end
					end
				end
				dif_pkg::ST_STEP: st_ff <= dif_pkg::ST_IDLE;
				default: st_ff <= dif_pkg::ST_IDLE;
			endcase
		end
	end

	// wide bandwidths in stepped mode are handed to the analog filters
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			analog_rbw_ff <= 1'b0;
		else
			analog_rbw_ff <= stepped && rbw_ff > dif_pkg::NARROW_MAX;
	end

	// scaling and log/linear choice stay with the host, trace data leaves unscaled
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign analog_gain = gain_ff;
	assign iq_i = iq_i_ff;
	assign iq_q = iq_q_ff;
	assign iq_valid = iq_v_ff;
	assign mag = mag_ff;
	assign phase = phase_ff;
	assign mp_valid = mp_v_ff;
	assign trace_pt = trace_ff;
	assign trace_valid = trace_v_ff;
	assign tune_hold = hold_ff;
	assign tune_step = step_ff;
	assign analog_rbw_sel = analog_rbw_ff;

	gain_down_a: assert property (ar_on && env_early > thr_ff[31:16] && gain_ff != '0
		|=> gain_ff == $past(gain_ff) - 2'h1) else $error("gain not lowered");
	gain_up_a: assert property (ar_on && env_early < thr_ff[15:0] && !(env_early > thr_ff[31:16])
		&& quiet_ff == dif_pkg::HOLD_LAST && gain_ff != dif_pkg::GAIN_MAX
		|=> gain_ff == $past(gain_ff) + 2'h1) else $error("gain not raised");
	gain_fixed_a: assert property (!ar_on |=> gain_ff == $past(ctrl_ff[5:4])) else $error("gain moved");
	comp_align_a: assert property (gdly[dif_pkg::AA_LEAD-1] == $past(gain_ff, 3))
		else $error("digital gain misaligned");
	iq_rate_a: assert property (pair_v |=> !pair_v ##1 pair_v) else $error("pair rate wrong");
	rbw_range_a: assert property (rbw_ff <= dif_pkg::RBW_MAX) else $error("bandwidth index out of range");
	decim_gap_a: assert property (iq_v_ff && decim_ff != '0 && $stable(decim_ff)
		|=> !iq_v_ff [*3]) else $error("decimation gap short");
	cordic_lat_a: assert property (iq_v_ff && !stepped && $stable(ctrl_ff) |-> ##14 mp_v_ff)
		else $error("magnitude missing");
	step_hold_a: assert property (step_ff |-> !hold_ff && $past(hold_ff)) else $error("step while held");
	analog_sel_a: assert property (stepped && rbw_ff > dif_pkg::NARROW_MAX |=> analog_rbw_sel)
		else $error("analog filter not selected");
	apb_ans_a: assert property (setup |=> pready) else $error("apb answer late");
	gain_cycle_c: cover property (ar_on && gain_ff == '0 ##[1:1000] gain_ff == dif_pkg::GAIN_MAX);
	trace_c: cover property (trace_v_ff);
	step_c: cover property (hold_ff ##1 step_ff);
endmodule : digital_if_receive_chain

//--- sim/front_end_model.sv
// behavioural analog front end: tone source, analog gain, anti-alias delay and 14-bit converter
`timescale 1ns/1ns
module front_end_model (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [dif_pkg::GAIN_W-1:0] analog_gain,
	input wire logic signed [15:0] tone_a,
	input wire logic signed [15:0] tone_b,
	output logic [dif_pkg::ADC_W-1:0] adc_data,
	output logic [15:0] env_early,
	output int clip_cnt
);
	int aa_q[$];
	logic [1:0] ph_ff;
	// quarter-rate tone a, b, -a, -b; the gain acts at the converter, so a late gain cut clips
	always @(posedge core_clk or negedge rst_n) begin
		int x;
		int e;
		if (!rst_n) begin
			ph_ff <= 2'h0;
			adc_data <= '0;
			env_early <= '0;
			clip_cnt <= 0;
			aa_q = {};
			repeat (dif_pkg::AA_LEAD) aa_q.push_back(0);
		end else begin
			ph_ff <= ph_ff + 2'h1;
			x = ph_ff[0] ? int'(tone_b) : int'(tone_a);
			aa_q.push_back(ph_ff[1] ? -x : x);
			x = aa_q.pop_front() * (1 << analog_gain);
			if (x > 8191 || x < -8192) begin
				clip_cnt <= clip_cnt + 1;
				x = x > 0 ? 8191 : -8192;
			end
			adc_data <= dif_pkg::ADC_W'(x);
			e = (tone_a < 0 ? -tone_a : tone_a) + (tone_b < 0 ? -tone_b : tone_b);
			e = e * (1 << analog_gain);
			env_early <= 16'(e > 65535 ? 65535 : e);
		end
	end
endmodule : front_end_model

//--- sim/tb.sv
// self-checking bench for the digital IF receive chain
`timescale 1ns/1ns
module tb;
	logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, err, mp_chk;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [dif_pkg::ADC_W-1:0] adc_data;
	logic [15:0] env_early, iq_i, iq_q, mag, trace_pt, phase;
	logic [1:0] analog_gain;
	logic iq_valid, mp_valid, trace_valid, tune_hold, tune_step, analog_rbw_sel;
	logic signed [15:0] tone_a, tone_b;
	int clip_cnt, n_errors, n_compared, n_iq = 0, n_mp = 0;
	logic [31:0] pair_q[$];
	logic [7:0] ofs[8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20};
	logic [31:0] rst_v[8] = '{32'h31, 32'h50, 32'h2, 32'h0, 32'hFF, 32'h1800_0400, 32'h3FF, 32'h2};

	digital_if_receive_chain dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.adc_data(adc_data), .env_early(env_early), .analog_gain(analog_gain), .iq_i(iq_i), .iq_q(iq_q),
		.iq_valid(iq_valid), .mag(mag), .phase(phase), .mp_valid(mp_valid), .trace_pt(trace_pt),
		.trace_valid(trace_valid), .tune_hold(tune_hold), .tune_step(tune_step), .analog_rbw_sel(analog_rbw_sel));
	front_end_model fe (.core_clk(core_clk), .rst_n(rst_n), .analog_gain(analog_gain), .tone_a(tone_a),
		.tone_b(tone_b), .adc_data(adc_data), .env_early(env_early), .clip_cnt(clip_cnt));

	// 125 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : finish_test

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// tolerant compare: an unknown never lands inside the window
	function automatic logic [31:0] near(input logic signed [31:0] seen, input int exp, input int tol);
		return (seen - exp <= tol && exp - seen <= tol) ? 32'(exp) : seen;
	endfunction : near

	task automatic hang(input string what);
		n_errors++;
		$display("Error timeout waiting for %s", what);
		finish_test();
	endtask : hang

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask : tick

	// apb master: request held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int k;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (k >= 16) hang("pready");
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask : apb

	// w selects iq_valid, trace_valid, tune_hold, tune_step
	task automatic wait_on(input int w, output int k);
		logic s;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
			s = w == 0 ? iq_valid : w == 1 ? trace_valid : w == 2 ? tune_hold : tune_step;
		end while (s !== 1'b1 && k < 3000);
		if (k >= 3000) hang("strobe");
	endtask : wait_on

	// pairs queue until their magnitude and phase come out
	always @(posedge core_clk) begin
		logic [31:0] pr;
		real i, q, ex;
		logic signed [15:0] d;
		if (iq_valid === 1'b1) begin
			n_iq <= n_iq + 1;
			pair_q.push_back({iq_i, iq_q});
		end
		if (mp_valid === 1'b1) n_mp <= n_mp + 1;
		if (mp_valid === 1'b1 && pair_q.size() > 0) begin
			pr = pair_q.pop_front();
			i = $signed(pr[31:16]);
			q = $signed(pr[15:0]);
			// cordic gain of 1.64676, halved by the magnitude bit slice
			ex = 0.82338 * $sqrt(i * i + q * q);
			d = 16'(phase - 16'(int'($atan2(q, i) * 10430.378)));
			if (mp_chk && ex < 65000.0) begin
				check("mag", near(32'(mag), int'(ex), 4 + int'(ex) / 100), 32'(int'(ex)));
				check("phase", near(d, 0, 48), '0);
			end
		end
	end

	// main sequence
	initial begin
		logic [7:0] v;
		int g0, r0, k, n, t;
		{psel, penable, pwrite, mp_chk} = '0;
		paddr = '0;
		pwdata = '0;
		tone_a = '0;
		tone_b = '0;
		rst_n = 1'b0;
		n_errors = 0;
		n_compared = 0;
		void'($urandom(32'hF04D7519));
		tick(5);
		rst_n <= 1'b1;
		tick(1);
		foreach (ofs[j]) begin
			apb(1'b0, ofs[j], '0);
			check("reset value", rd, rst_v[j]);
		end
		apb(1'b1, 8'h24, 32'hFFFF_FFFF);
		apb(1'b0, 8'h24, '0);
		check("unmapped", {err, rd[30:0]}, 32'h8000_0000);
		for (k = 0; k < 4; k++) begin
			v = k == 0 ? 8'h9F : k == 1 ? 8'hA0 : 8'($urandom());
			apb(1'b1, dif_pkg::OFS_RBW, 32'(v));
			apb(1'b0, dif_pkg::OFS_RBW, '0);
			check("rbw", rd, v > 8'h9F ? 32'h9F : 32'(v));
		end
		apb(1'b1, dif_pkg::OFS_RBW, 32'h50);
		$display("done: registers");
		for (t = 0; analog_gain !== 2'h3 && t < 6000; t++) tick(1);
		check("quiet gain", 32'(analog_gain), 32'h3);
		tone_a <= 16'sd1100;
		tick(400);
		check("no clip", 32'(clip_cnt), '0);
		check("cut", 32'(analog_gain < 2'h3), 32'h1);
		apb(1'b0, dif_pkg::OFS_STATUS, '0);
		check("status gain", 32'(rd[1:0]), 32'(analog_gain));
		tone_a <= 16'sd200;
		g0 = analog_gain;
		for (t = 0; analog_gain == g0 && t < 2000; t++) begin
			if (t == 1100) r0 = $signed(iq_i);
			tick(1);
		end
		check("rise time", near(t, 1250, 20), 1250);
		check("rise", 32'(analog_gain), 32'(g0 + 1));
		tick(1100);
		check("rescale", near($signed(iq_i), r0, 4 + (r0 < 0 ? -r0 : r0) / 32), 32'(r0));
		apb(1'b1, dif_pkg::OFS_CTRL, 32'h10);
		tone_a <= 16'sd30;
		for (t = 0, n = 0; t < 1400; t++, tick(1)) n += (t > 10 && analog_gain !== 2'h1);
		check("manual gain", n, 0);
		$display("done: autorange");
		apb(1'b1, dif_pkg::OFS_CTRL, 32'h30);
		for (k = 0; k < 3; k++) begin
			tone_a <= 16'(($urandom_range(1) ? 1 : -1) * int'($urandom_range(900, 100)));
			tone_b <= 16'(($urandom_range(1) ? 1 : -1) * int'($urandom_range(900, 100)));
			tick(1200);
			// converter lag puts phases b, a, b, a on the I, Q, I, Q slots
			check("i sign", iq_i[15], tone_b > 0);
			check("q sign", iq_q[15], tone_a > 0);
			mp_chk <= 1'b1;
			n = n_mp;
			t = n_iq;
			tick(60);
			mp_chk <= 1'b0;
			check("mp rate", n_mp - n, 30);
			check("iq rate", n_iq - t, 30);
		end
		for (k = 0; k < 2; k++) begin
			g0 = $urandom_range(6, 1);
			apb(1'b1, dif_pkg::OFS_DECIM, g0);
			tick(100);
			wait_on(0, t);
			wait_on(0, t);
			check("decimation", t, 2 * (g0 + 1));
		end
		apb(1'b1, dif_pkg::OFS_DECIM, '0);
		apb(1'b1, dif_pkg::OFS_BUCKET, 32'h3);
		for (k = 0; k < 2; k++) begin
			apb(1'b1, dif_pkg::OFS_CTRL, k ? 32'h34 : 32'h30);
			tick(400);
			wait_on(1, t);
			n = n_mp;
			wait_on(1, t);
			check("bucket", n_mp - n, 4);
			check("trace", near(32'(trace_pt), int'(mag), 4 + int'(mag) / 50), 32'(mag));
		end
		$display("done: stream");
		apb(1'b1, dif_pkg::OFS_RBW, 32'h3);
		apb(1'b1, dif_pkg::OFS_STEPLEN, 32'h3);
		apb(1'b1, dif_pkg::OFS_CTRL, 32'h33);
		tone_a <= 16'sd900;
		tick(30);
		n = n_mp;
		check("analog rbw off", analog_rbw_sel, 1'b0);
		wait_on(3, t);
		for (k = 0; k < 2; k++) begin
			wait_on(2, t);
			check("hold gap", t, 2);
			for (g0 = 0, t = 0; tune_step !== 1'b1 && t < 3000; t++, tick(1)) g0 += (tune_hold && iq_valid);
			check("pairs per step", g0, 4);
			check("hold released", tune_hold, 1'b0);
		end
		check("stepped gain", 32'(analog_gain), 32'h3);
		check("no mag", n_mp - n, 0);
		apb(1'b1, dif_pkg::OFS_RBW, 32'h40);
		tick(2);
		check("analog rbw on", analog_rbw_sel, 1'b1);
		$display("done: stepped");
		finish_test();
	end
endmodule : tb
